/* design/mcr_top.sv */
// Machine cycle rate manager: source select, 4/64/1024 divider, hardware speed restore, status.
// Assumes source ticks, interrupt and serial inputs are synchronous one-clock-wide levels or pulses.
`timescale 1ns/1ns
`include "mcr_defs.svh"

module mcr_top #(
   parameter int NUM_EXT      = 6,
   parameter int WARMUP_TICKS = `MCR_WARMUP_TICKS
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [`MCR_ADDR_W-1:0] awaddr,
   input  wire logic                   awvalid,
   output      logic                   awready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output      logic                   wready,
   output      logic [1:0]             bresp,
   output      logic                   bvalid,
   input  wire logic                   bready,
   input  wire logic [`MCR_ADDR_W-1:0] araddr,
   input  wire logic                   arvalid,
   output      logic                   arready,
   output      logic [31:0]            rdata,
   output      logic [1:0]             rresp,
   output      logic                   rvalid,
   input  wire logic                   rready,
   input  wire logic                   xtal_tick,
   input  wire logic                   ring_tick,
   input  wire logic [NUM_EXT-1:0]     ext_irq_req,
   input  wire logic [NUM_EXT-1:0]     ext_irq_enable,
   input  wire logic [NUM_EXT-1:0]     ext_irq_high_prio,
   input  wire logic                   powerfail_level_active,
   input  wire logic                   high_level_active,
   input  wire logic                   low_level_active,
   input  wire logic                   port0_rx_busy,
   input  wire logic                   port0_tx_busy,
   input  wire logic                   port1_rx_busy,
   input  wire logic                   port1_tx_busy,
   input  wire logic                   port0_rx_enable,
   input  wire logic                   port0_start_edge,
   input  wire logic                   port1_rx_enable,
   input  wire logic                   port1_start_edge,
   input  wire logic                   port0_tx_buffer_write,
   input  wire logic                   port1_tx_buffer_write,
   output      logic                   machine_cycle,
   output      logic                   ring_active_flag,
   output      logic                   crystal_amp_disable,
   output      logic                   crystal_ready_flag
);

   // Register bus plumbing
   logic                   wr_en;
   logic [`MCR_ADDR_W-1:0] wr_addr;
   logic [31:0]            wr_data;
   logic [3:0]             wr_strb;
   logic                   wr_ok;
   logic [31:0]            rd_data;
   logic                   rd_ok;

   // Control state
   mcr_pkg::mcr_div_e div_req;
   mcr_pkg::mcr_div_e div_active;
   logic              auto_restore_enable;
   logic              source_select;
   logic              src_active;
   logic [1:0]        arm;
   logic [16:0]       warm_cnt;
   logic              restore_event;
   logic [NUM_EXT-1:0] ext_ok;
   logic              src_tick;

   logic wr_ext;
   logic wr_pwr;
   logic lane0;
   logic [7:0] wbyte;
   mcr_pkg::mcr_div_e wr_div;
   logic div_write_ok;
   logic src_write_ok;
   logic amp_write_ok;

   mcr_axil u_axil (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .wr_ok   (wr_ok),
      .rd_data (rd_data),
      .rd_ok   (rd_ok)
   );

   // Write decode; byte lane 0 carries all eight register bits
   assign wr_ext = wr_en && (wr_addr[11:2] == `MCR_IDX_EXT_IRQ) && (wr_addr[1:0] == 2'h0);
   assign wr_pwr = wr_en && (wr_addr[11:2] == `MCR_IDX_PWR_CTRL) && (wr_addr[1:0] == 2'h0);
   assign wr_ok  = (wr_addr[1:0] == 2'h0) &&
                   ((wr_addr[11:2] == `MCR_IDX_EXT_IRQ) || (wr_addr[11:2] == `MCR_IDX_PWR_CTRL) ||
                    (wr_addr[11:2] == `MCR_IDX_STATUS));
   assign lane0  = wr_strb[0];
   assign wbyte  = wr_data[7:0];
   assign wr_div = mcr_pkg::mcr_div_e'(wbyte[`MCR_DIV_HI_BIT:`MCR_DIV_LO_BIT]);

   // Reduced rates only from a settled four-clock rate; reserved code is dropped
   assign div_write_ok = (wr_div == mcr_pkg::mcr_div_4) ||
                         ((wr_div != mcr_pkg::mcr_div_rsvd) &&
                          (div_active == mcr_pkg::mcr_div_4) &&
                          (div_req == mcr_pkg::mcr_div_4));
   // Crystal may be chosen only once warmed and running
   assign src_write_ok = !wbyte[`MCR_SRC_SEL_BIT] || source_select ||
                         (crystal_ready_flag && !crystal_amp_disable);
   // Amplifier may be turned off only while the ring is chosen
   assign amp_write_ok = !wbyte[`MCR_AMP_OFF_BIT] || !source_select;

   // Interrupt may restore speed only if the in-service level would let it through
   genvar gi;
   generate
      for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
         assign ext_ok[gi] = ext_irq_req[gi] && ext_irq_enable[gi] &&
                             !powerfail_level_active && !high_level_active &&
                             (ext_irq_high_prio[gi] || !low_level_active);
      end
   endgenerate

   assign restore_event = auto_restore_enable &&
                          ((|ext_ok) ||
                           (port0_rx_enable && port0_start_edge) ||
                           (port1_rx_enable && port1_start_edge) ||
                           port0_tx_buffer_write || port1_tx_buffer_write);

   // Divider request and restore enable; a restore wins over a same-cycle write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_req             <= mcr_pkg::mcr_div_e'(`MCR_DIV_RESET);
         auto_restore_enable <= 1'b0;
      end else begin
         if (wr_pwr && lane0) begin
            auto_restore_enable <= wbyte[`MCR_RESTORE_EN_BIT];
            if (div_write_ok) begin
               div_req <= wr_div;
            end
         end
         if (restore_event) begin
            div_req <= mcr_pkg::mcr_div_4;
         end
      end
   end

   // Source request and amplifier control
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         source_select       <= `MCR_SRC_RESET;
         crystal_amp_disable <= 1'b0;
      end else begin
         if (wr_ext && lane0 && src_write_ok) begin
            source_select <= wbyte[`MCR_SRC_SEL_BIT];
         end
         if (wr_pwr && lane0 && amp_write_ok) begin
            crystal_amp_disable <= wbyte[`MCR_AMP_OFF_BIT];
         end
      end
   end

   // Crystal warm-up; counts only crystal ticks after the amplifier is back on
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         warm_cnt           <= 17'h00000;
         crystal_ready_flag <= `MCR_RDY_RESET;
      end else if (crystal_amp_disable) begin
         warm_cnt           <= 17'h00000;
         crystal_ready_flag <= 1'b0;
      end else if (!crystal_ready_flag && xtal_tick) begin
         if (warm_cnt == 17'(WARMUP_TICKS - 1)) begin
            crystal_ready_flag <= 1'b1;
         end
         warm_cnt <= warm_cnt + 17'h00001;
      end
   end

   // Arm count: 2 lets one further machine cycle pass, 1 applies at the next boundary
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arm <= 2'h0;
      end else if (restore_event) begin
         arm <= 2'h1;
      end else if ((wr_pwr || wr_ext) && lane0) begin
         arm <= 2'h2;
      end else if (machine_cycle && (arm != 2'h0)) begin
         arm <= arm - 2'h1;
      end
   end

   // Active divider and source change only on a boundary pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_active       <= mcr_pkg::mcr_div_e'(`MCR_DIV_RESET);
         src_active       <= `MCR_SRC_RESET;
         ring_active_flag <= 1'b0;
      end else if (machine_cycle && (arm == 2'h1)) begin
         div_active       <= div_req;
         src_active       <= source_select;
         ring_active_flag <= !source_select;
      end
   end

   // One divider for both sources; src_active picks crystal or ring ticks
   assign src_tick = src_active ? xtal_tick : ring_tick;

   mcr_cycle_div u_div (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .src_tick   (src_tick),
      .div_code   (div_active),
      .cycle_tick (machine_cycle)
   );

   // Read mux; reserved bits read zero
   always_comb begin
      rd_data = 32'h00000000;
      rd_ok   = (araddr[1:0] == 2'h0);
      case (araddr[11:2])
         `MCR_IDX_EXT_IRQ: begin
            rd_data[`MCR_SRC_SEL_BIT]   = source_select;
            rd_data[`MCR_RING_FLAG_BIT] = ring_active_flag;
         end
         `MCR_IDX_PWR_CTRL: begin
            rd_data[`MCR_DIV_HI_BIT:`MCR_DIV_LO_BIT] = div_req;
            rd_data[`MCR_RESTORE_EN_BIT]             = auto_restore_enable;
            rd_data[`MCR_AMP_OFF_BIT]                = crystal_amp_disable;
         end
         `MCR_IDX_STATUS: begin
            rd_data[7:5] = {powerfail_level_active, high_level_active, low_level_active};
            rd_data[`MCR_XTAL_RDY_BIT] = crystal_ready_flag;
            rd_data[3:0] = {port1_tx_busy, port1_rx_busy, port0_tx_busy, port0_rx_busy};
         end
         default: begin
            rd_ok = 1'b0;
         end
      endcase
      // Misaligned reads answer with an error and must not leak register bits
      if (araddr[1:0] != 2'h0) begin
         rd_data = 32'h00000000;
      end
   end

endmodule // mcr_top

/* pkg/mcr_defs.svh */
// Constants of the machine cycle rate manager: register indexes, field positions, resets, counts.
// Assumes the includer compares byte addresses against four times each register index.
`ifndef MCR_DEFS_SVH
`define MCR_DEFS_SVH

`define MCR_ADDR_W         12
`define MCR_IDX_EXT_IRQ    10'h091
`define MCR_IDX_PWR_CTRL   10'h0c4
`define MCR_IDX_STATUS     10'h0c5

`define MCR_DIV_HI_BIT     7
`define MCR_DIV_LO_BIT     6
`define MCR_RESTORE_EN_BIT 5
`define MCR_AMP_OFF_BIT    3
`define MCR_SRC_SEL_BIT    3
`define MCR_RING_FLAG_BIT  2
`define MCR_XTAL_RDY_BIT   4

`define MCR_DIV_RESET      2'h1
`define MCR_SRC_RESET      1'h1
`define MCR_RDY_RESET      1'h1

`define MCR_CLKS_4         11'h004
`define MCR_CLKS_64        11'h040
`define MCR_CLKS_1024      11'h400
`define MCR_WARMUP_TICKS   65536

`define MCR_RESP_OKAY      2'h0
`define MCR_RESP_SLVERR    2'h2

`endif

/* pkg/mcr_pkg.sv */
// Types of the machine cycle rate manager.
// Assumes nothing of its surroundings.
package mcr_pkg;

   typedef enum logic [1:0] {
      mcr_div_rsvd = 2'h0,
      mcr_div_4    = 2'h1,
      mcr_div_64   = 2'h2,
      mcr_div_1024 = 2'h3
   } mcr_div_e;

   typedef logic [10:0] mcr_cnt_t;

endpackage

/* design/mcr_cycle_div.sv */
// Machine cycle divider: counts source ticks and emits one pulse per machine cycle.
// Assumes the divider code only changes in the cycle of a boundary pulse.
`timescale 1ns/1ns
`include "mcr_defs.svh"

module mcr_cycle_div (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              src_tick,
   input  wire mcr_pkg::mcr_div_e div_code,
   output      logic              cycle_tick
);

   mcr_pkg::mcr_cnt_t cnt;
   mcr_pkg::mcr_cnt_t last;

   always_comb begin
      case (div_code)
         mcr_pkg::mcr_div_64:   last = `MCR_CLKS_64 - 11'h001;
         mcr_pkg::mcr_div_1024: last = `MCR_CLKS_1024 - 11'h001;
         default:               last = `MCR_CLKS_4 - 11'h001;
      endcase
   end

   // Counter restarts at each boundary, so a new ratio never cuts a cycle short
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt        <= 11'h000;
         cycle_tick <= 1'b0;
      end else begin
         cycle_tick <= src_tick && (cnt == last);
         if (src_tick) begin
            cnt <= (cnt == last) ? 11'h000 : cnt + 11'h001;
         end
      end
   end

endmodule // mcr_cycle_div

/* design/mcr_axil.sv */
// AXI4-Lite slave front end: takes address and data in either order, one access each way.
// Assumes the owner decodes the address and answers wr_ok and rd_ok in the same cycle.
`timescale 1ns/1ns
`include "mcr_defs.svh"

module mcr_axil (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [`MCR_ADDR_W-1:0] awaddr,
   input  wire logic                   awvalid,
   output      logic                   awready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output      logic                   wready,
   output      logic [1:0]             bresp,
   output      logic                   bvalid,
   input  wire logic                   bready,
   input  wire logic [`MCR_ADDR_W-1:0] araddr,
   input  wire logic                   arvalid,
   output      logic                   arready,
   output      logic [31:0]            rdata,
   output      logic [1:0]             rresp,
   output      logic                   rvalid,
   input  wire logic                   rready,
   output      logic                   wr_en,
   output      logic [`MCR_ADDR_W-1:0] wr_addr,
   output      logic [31:0]            wr_data,
   output      logic [3:0]             wr_strb,
   input  wire logic                   wr_ok,
   input  wire logic [31:0]            rd_data,
   input  wire logic                   rd_ok
);

   logic aw_held;
   logic w_held;

   assign wr_en = aw_held && w_held && !bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready  <= 1'b1;
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         wr_addr <= '0;
         wr_data <= 32'h00000000;
         wr_strb <= 4'h0;
         bvalid  <= 1'b0;
         bresp   <= `MCR_RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            aw_held <= 1'b1;
            wr_addr <= awaddr;
         end
         if (wvalid && wready) begin
            wready  <= 1'b0;
            w_held  <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
         if (wr_en) begin
            bvalid  <= 1'b1;
            bresp   <= wr_ok ? `MCR_RESP_OKAY : `MCR_RESP_SLVERR;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // Read data is captured at the address edge, so rdata stands unchanged while stalled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h00000000;
         rresp   <= `MCR_RESP_OKAY;
      end else begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_data;
            rresp   <= rd_ok ? `MCR_RESP_OKAY : `MCR_RESP_SLVERR;
         end
         if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

endmodule // mcr_axil

/* testbench/mcr_top_properties.sv */
// Concurrent checks on the ports of the machine cycle rate manager top.
// Assumes one aclk domain and source ticks at most one per aclk cycle.
`timescale 1ns/1ns
`include "mcr_defs.svh"
module mcr_top_properties #(
   parameter int WARMUP_TICKS = `MCR_WARMUP_TICKS
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic        xtal_tick,
   input wire logic        machine_cycle,
   input wire logic        crystal_amp_disable,
   input wire logic        crystal_ready_flag
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Crystal ticks seen since the amplifier came back on
   int warm_seen;
   always_ff @(posedge aclk) begin
      if (!aresetn || crystal_amp_disable) begin
         warm_seen <= 0;
      end else if (xtal_tick && !crystal_ready_flag) begin
         warm_seen <= warm_seen + 1;
      end
   end

   a_cycle_min_gap: assert property (machine_cycle |=> !machine_cycle [*3])
      else $error("machine cycle pulses closer than four clocks");
   a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before bready");
   a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped before rready");
   a_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write response late");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   a_busy_blocks: assert property (bvalid |-> !awready && !wready)
      else $error("write accepted while response pending");
   a_warmup_count: assert property ($rose(crystal_ready_flag) |-> warm_seen == WARMUP_TICKS)
      else $error("crystal ready set before warm-up");

   cover property (machine_cycle);
   cover property ($rose(crystal_ready_flag));
   cover property (bvalid && bresp == 2'h2);
   cover property (rvalid && !rready);
endmodule // mcr_top_properties

bind mcr_top mcr_top_properties #(.WARMUP_TICKS(WARMUP_TICKS)) chk_u (.aclk, .aresetn, .awvalid, .awready, .wvalid,
   .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .xtal_tick, .machine_cycle,
   .crystal_amp_disable, .crystal_ready_flag);

/* testbench/mcr_far_end.sv */
// Far side: crystal and ring ticks, interrupt controller and serial port event pulses.
// Assumes the bench raises ev_go for one cycle per event.
`timescale 1ns/1ns
module mcr_far_end (
   input  wire logic       aclk,
   input  wire logic       amp_off,
   input  wire logic       ev_go,
   input  wire logic [2:0] ev_sel,
   output      logic       xtal_tick = 1'h0,
   output      logic       ring_tick = 1'h0,
   output      logic [5:0] irq_req   = 6'h00,
   output      logic [3:0] ser_ev    = 4'h0
);
   always @(posedge aclk) begin
      xtal_tick <= !amp_off;
      ring_tick <= !ring_tick;
      irq_req <= 6'h00;
      ser_ev <= 4'h0;
      if (ev_go) begin
         if (ev_sel < 3'h3) irq_req[ev_sel] <= 1'h1;
         else ser_ev[ev_sel-3'h3] <= 1'h1;
      end
   end
endmodule // mcr_far_end

/* testbench/tb_top.sv */
// Self-checking bench for the machine cycle rate manager.
// Assumes the design, its checker and the far-side model compile first.
`timescale 1ns/1ns
`include "mcr_defs.svh"
module tb_top;
   typedef struct {logic [11:0] a; logic w; logic [7:0] d; logic [7:0] e; logic [1:0] r;} mcr_row_s;
   typedef struct {logic [2:0] sel; logic sw; logic en1; logic [1:0] dv; logic rs;} mcr_ev_s;
   logic        aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic        arvalid = 1'h0, rready = 1'h0, p1_ren = 1'h0, ev_go = 1'h0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic [7:0]  stat = 8'h00;
   logic [5:0]  irq_en = 6'h03, irq_hi = 6'h01, irq_req;
   logic [2:0]  ev_sel = 3'h0;
   logic [3:0]  ser_ev;
   logic [1:0]  bresp, rresp;
   logic        awready, wready, bvalid, arready, rvalid, xtal_tick, ring_tick;
   logic        machine_cycle, ring_active_flag, crystal_amp_disable, crystal_ready_flag;
   int          failures = 0, checks = 0, cyc = 0, s, lag = 0;
   int          pt[$];
   mcr_row_s rows[8] = '{'{12'h310, 1'h0, 8'h00, 8'h40, 2'h0}, '{12'h244, 1'h0, 8'h00, 8'h08, 2'h0},
      '{12'h314, 1'h0, 8'h00, 8'h10, 2'h0}, '{12'h310, 1'h1, 8'h20, 8'h60, 2'h0},
      '{12'h310, 1'h1, 8'h00, 8'h40, 2'h0}, '{12'h314, 1'h1, 8'hff, 8'h10, 2'h0},
      '{12'h300, 1'h1, 8'h55, 8'h00, 2'h2}, '{12'h311, 1'h0, 8'h00, 8'h00, 2'h2}};
   // Blocked sources first, so the rate stays reduced until a real restore
   mcr_ev_s evs[9] = '{'{3'h0, 1'h0, 1'h0, 2'h2, 1'h0}, '{3'h1, 1'h1, 1'h0, 2'h2, 1'h0},
      '{3'h2, 1'h1, 1'h0, 2'h2, 1'h0}, '{3'h4, 1'h1, 1'h0, 2'h2, 1'h0}, '{3'h0, 1'h1, 1'h0, 2'h2, 1'h1},
      '{3'h3, 1'h1, 1'h0, 2'h2, 1'h1}, '{3'h4, 1'h1, 1'h1, 2'h2, 1'h1}, '{3'h5, 1'h1, 1'h1, 2'h2, 1'h1},
      '{3'h6, 1'h1, 1'h1, 2'h3, 1'h1}};

   mcr_top #(.WARMUP_TICKS(16)) dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .xtal_tick, .ring_tick, .ext_irq_req(irq_req), .ext_irq_enable(irq_en), .ext_irq_high_prio(irq_hi),
      .powerfail_level_active(stat[7]), .high_level_active(stat[6]), .low_level_active(stat[5]),
      .port0_rx_busy(stat[0]), .port0_tx_busy(stat[1]), .port1_rx_busy(stat[2]), .port1_tx_busy(stat[3]),
      .port0_rx_enable(1'h1), .port0_start_edge(ser_ev[0]), .port1_rx_enable(p1_ren),
      .port1_start_edge(ser_ev[1]), .port0_tx_buffer_write(ser_ev[2]), .port1_tx_buffer_write(ser_ev[3]),
      .machine_cycle, .ring_active_flag, .crystal_amp_disable, .crystal_ready_flag);
   mcr_far_end far_u (.aclk, .amp_off(crystal_amp_disable), .ev_go, .ev_sel, .xtal_tick, .ring_tick, .irq_req,
      .ser_ev);

   always #50 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (machine_cycle === 1'h1) pt.push_back(cyc);
   end

   function automatic int gp(input int i);
      return pt[i+1] - pt[i];
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic upto(input int t);
      int k;
      k = 0;
      while (pt.size() < t + 1 && k < 5000) begin
         @(posedge aclk);
         k++;
      end
      if (k >= 5000) failures++;
   endtask
   task automatic axw(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= (lag == 0);
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         n++;
         if (n >= lag) bready <= 1'h1;
      end while (!(bvalid && bready && !awvalid && !wvalid) && n < 100);
      bready <= 1'h0;
      if (n >= 100) failures++;
      chk({30'h0, bresp}, {30'h0, er});
      @(posedge aclk);
   endtask
   task automatic axr(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= (lag == 0);
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
         n++;
         if (n >= lag) rready <= 1'h1;
      end while (!(rvalid && rready && !arvalid) && n < 100);
      rready <= 1'h0;
      if (n >= 100) failures++;
      chk(rdata, {24'h000000, e});
      chk({30'h0, rresp}, {30'h0, er});
      @(posedge aclk);
   endtask
   task automatic fire(input logic [2:0] sel);
      ev_sel <= sel;
      ev_go <= 1'h1;
      @(posedge aclk);
      ev_go <= 1'h0;
      repeat (2) @(posedge aclk);
   endtask
   task automatic close_out;
      if (failures == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      foreach (rows[i]) begin
         if (rows[i].w) axw(rows[i].a, rows[i].d, rows[i].r);
         axr(rows[i].a, rows[i].e, rows[i].r);
      end
      s = pt.size();
      upto(s + 2);
      chk(32'(gp(s + 1)), 32'h4);
      for (int b = 0; b < 8; b++) begin
         stat <= 8'h01 << b;
         axr(12'h314, (8'h01 << b) | 8'h10, 2'h0);
      end
      stat <= 8'h00;
      s = pt.size();
      axw(12'h310, 8'h80, 2'h0);
      upto(s + 3);
      chk(32'(gp(s)), 32'h4);
      chk(32'(gp(s + 2)), 32'h40);
      // Late ready, so the response must stand while stalled
      lag = 3;
      axw(12'h310, 8'hc0, 2'h0);
      axr(12'h310, 8'h80, 2'h0);
      lag = 0;
      stat <= 8'h20;
      foreach (evs[i]) begin
         p1_ren <= evs[i].en1;
         axw(12'h310, {evs[i].dv, evs[i].sw, 5'h00}, 2'h0);
         s = pt.size();
         upto(s + 3);
         chk(32'(gp(pt.size() - 2)), evs[i].dv == 2'h3 ? 32'h400 : 32'h40);
         fire(evs[i].sel);
         s = pt.size();
         upto(s + 2);
         chk(32'(gp(s + 1)), evs[i].rs ? 32'h4 : 32'h40);
      end
      stat <= 8'h00;
      axw(12'h244, 8'h00, 2'h0);
      s = pt.size();
      upto(s + 3);
      chk(32'(gp(s + 2)), 32'h8);
      chk({31'h0, ring_active_flag}, 32'h1);
      axr(12'h244, 8'h04, 2'h0);
      axw(12'h310, 8'ha8, 2'h0);
      chk({31'h0, crystal_amp_disable}, 32'h1);
      s = pt.size();
      upto(s + 2);
      chk(32'(gp(s + 1)), 32'h80);
      fire(3'h6);
      s = pt.size();
      upto(s + 2);
      chk(32'(gp(s + 1)), 32'h8);
      chk({31'h0, ring_active_flag}, 32'h1);
      axw(12'h310, 8'h40, 2'h0);
      axw(12'h244, 8'h08, 2'h0);
      axr(12'h244, 8'h04, 2'h0);
      s = 0;
      while (crystal_ready_flag !== 1'h1 && s < 200) begin
         @(posedge aclk);
         s++;
      end
      chk({31'h0, crystal_ready_flag}, 32'h1);
      axw(12'h244, 8'h08, 2'h0);
      s = pt.size();
      upto(s + 3);
      chk(32'(gp(s + 2)), 32'h4);
      chk({31'h0, ring_active_flag}, 32'h0);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      axr(12'h310, 8'h40, 2'h0);
      axr(12'h244, 8'h08, 2'h0);
      close_out;
   end
   initial begin
      repeat (60000) @(posedge aclk);
      failures++;
      close_out;
   end
endmodule // tb_top
